//--- hdl/bip_port.sv
// Purpose: 8-bit bidirectional port as seen by the core's port instructions
// Assumes: op_in is held for a whole instruction cycle of four clocks
// Notes: pin enables are active low while the port drives the pin
//
// Contract
// [RULE1] bit set/clear reads whole port, alters one bit, writes full byte to latches
// [RULE2] input bits contribute pin level, stored into their own latch
// [RULE3] latch keeps last written value; output mode drives that value
// [RULE4] writes commit to latches at end of the instruction cycle
// [RULE5] reads sample pins at start of the instruction cycle
// [RULE6] software places an unrelated instruction between a write and a read
// [RULE7] input pin reading high during read-modify-write writes high into latch
// [RULE8] pin driven only when direction is output, else released and read
`timescale 1ns/1ps
`default_nettype none
`include "bip_port_regs.svh"
module bip_port
  import bip_port_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic start_in,
  input var bip_op_t op_in,
  input wire logic [2:0] bit_sel_in,
  input wire logic [7:0] data_in,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oen_out,
  output logic [7:0] read_data_out,
  output logic read_valid_out,
  output logic busy_out
);
  bip_state_t state;
  bip_state_t next_state;
  logic [`BIP_PHASE_W-1:0] phase;
  logic [7:0] latch;
  logic [7:0] dir;
  logic [7:0] sample;
  bip_op_t op;
  logic [2:0] bit_sel;
  logic [7:0] wdata;

  function automatic logic [7:0] bit_mask(input logic [2:0] idx);
    bit_mask = 8'h01 << idx;
  endfunction

  wire logic cycle_end = (state == BIP_ST_EXEC) && (phase == `BIP_PHASE_LAST);
  wire logic [7:0] sel_mask = bit_mask(bit_sel);
  // whole-port sample with one bit altered
  wire logic [7:0] rmw_set = sample | sel_mask; // [RULE1] [RULE2] [RULE7]
  wire logic [7:0] rmw_clr = sample & ~sel_mask; // [RULE1] [RULE2]
  wire logic [7:0] next_latch =
    (op == BIP_OP_WRITE) ? wdata :
    (op == BIP_OP_BIT_SET) ? rmw_set :
    (op == BIP_OP_BIT_CLEAR) ? rmw_clr : latch; // [RULE3]
  wire logic [7:0] next_dir = (op == BIP_OP_DIR_LOAD) ? wdata : dir;
  // pin reads: driven bits show the pin, which reflects the latch
  wire logic [7:0] pin_level = pin_in; // [RULE8]

  always_comb begin
    next_state = state;
    case (state)
      BIP_ST_IDLE: begin
        if (start_in && op_in != BIP_OP_NONE) begin
          next_state = BIP_ST_EXEC;
        end
      end
      BIP_ST_EXEC: begin
        if (phase == `BIP_PHASE_LAST) begin
          next_state = BIP_ST_IDLE;
        end
      end
      default: next_state = BIP_ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      state <= BIP_ST_IDLE;
      phase <= '0;
      op <= BIP_OP_NONE;
      bit_sel <= 3'h0;
      wdata <= 8'h00;
      sample <= 8'h00;
    end else begin
      state <= next_state;
      phase <= (state == BIP_ST_EXEC) ? phase + 2'h1 : 2'h0;
      if (state == BIP_ST_IDLE && start_in) begin
        op <= op_in;
        bit_sel <= bit_sel_in;
        wdata <= data_in;
        sample <= pin_level; // [RULE5]
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      latch <= `BIP_LATCH_RST;
      dir <= `BIP_DIR_RST;
    end else if (cycle_end) begin
      latch <= next_latch; // [RULE4] [RULE3]
      dir <= next_dir; // [RULE4]
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      pin_out <= `BIP_LATCH_RST;
      pin_oen_out <= 8'hFF;
      read_data_out <= 8'h00;
      read_valid_out <= 1'b0;
      busy_out <= 1'b0;
    end else begin
      pin_out <= cycle_end ? next_latch : latch; // [RULE8]
      pin_oen_out <= cycle_end ? next_dir : dir; // [RULE8]
      read_valid_out <= cycle_end && (op == BIP_OP_READ);
      if (cycle_end && op == BIP_OP_READ) begin
        read_data_out <= sample; // [RULE5]
      end
      busy_out <= (next_state == BIP_ST_EXEC);
    end
  end
endmodule // bip_port
`default_nettype wire

//--- hdl/bip_port_regs.svh
// Purpose: constants for the bidirectional port with read-modify-write
// Assumes: one instruction cycle is a fixed number of core clocks
// Notes: definitions only
`ifndef BIP_PORT_REGS_SVH
`define BIP_PORT_REGS_SVH
`define BIP_WIDTH 8
`define BIP_LATCH_RST 8'h00
`define BIP_DIR_RST 8'hFF
`define BIP_CYCLE_CLKS 4
`define BIP_PHASE_W 2
`define BIP_PHASE_LAST 2'h3
`endif

//--- hdl/bip_port_pkg.sv
// Purpose: types for the bidirectional port
// Assumes: nothing
// Notes: operation codes issued by the core
package bip_port_pkg;
  typedef enum logic [2:0] {
    BIP_OP_NONE,
    BIP_OP_WRITE,
    BIP_OP_READ,
    BIP_OP_BIT_SET,
    BIP_OP_BIT_CLEAR,
    BIP_OP_DIR_LOAD
  } bip_op_t;
  typedef enum logic [1:0] {
    BIP_ST_IDLE,
    BIP_ST_EXEC
  } bip_state_t;
endpackage

//--- verif/bip_port_checker.sv
// Purpose: timing and value checks on the port
// Assumes: four-clock instruction cycle
// Notes: bound to bip_port
`timescale 1ns/1ps
`default_nettype none
module bip_port_checker import bip_port_pkg::*; (
  input wire logic core_clk_in, resetn_in, start_in,
  input var bip_op_t op_in,
  input wire logic [2:0] bit_sel_in,
  input wire logic [7:0] data_in, pin_in, pin_out, pin_oen_out, read_data_out,
  input wire logic read_valid_out, busy_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  wire logic tk = start_in && !busy_out;
  a_set_rmw: assert property (tk && op_in == BIP_OP_BIT_SET |-> ##5
    pin_out == ($past(pin_in, 5) | 8'h01 << $past(bit_sel_in, 5))) else $error("set");
  a_clear_rmw: assert property (tk && op_in == BIP_OP_BIT_CLEAR |-> ##5
    pin_out == ($past(pin_in, 5) & ~(8'h01 << $past(bit_sel_in, 5)))) else $error("clr");
  a_write_at_end: assert property (tk && op_in == BIP_OP_WRITE |->
    ##1 $stable(pin_out)[*4] ##1 pin_out == $past(data_in, 5)) else $error("write");
  a_read_at_start: assert property (tk && op_in == BIP_OP_READ |-> ##5
    read_valid_out && read_data_out == $past(pin_in, 5)) else $error("read");
  a_latch_hold: assert property (!$stable(pin_out) |-> $past(busy_out)) else $error("hold");
  a_dir_load: assert property (tk && op_in == BIP_OP_DIR_LOAD |-> ##5
    pin_oen_out == $past(data_in, 5)) else $error("dir");
  a_high_kept: assert property (tk && op_in == BIP_OP_BIT_SET |-> ##5
    (pin_out & $past(pin_in, 5)) == $past(pin_in, 5)) else $error("high");
endmodule // bip_port_checker
bind bip_port bip_port_checker bip_port_checker_inst (.core_clk_in, .resetn_in, .start_in,
  .op_in, .bit_sel_in, .data_in, .pin_in, .pin_out, .pin_oen_out, .read_data_out,
  .read_valid_out, .busy_out);
`default_nettype wire

//--- verif/bip_pin_model.sv
// Purpose: resolved pin levels
// Assumes: released pins follow ext_in
// Notes: ext_in holds pull-up levels
`timescale 1ns/1ps
`default_nettype none
module bip_pin_model (
  input wire logic [7:0] drive_in, oen_in, ext_in,
  output logic [7:0] level_out
);
  assign level_out = (drive_in & ~oen_in) | (ext_in & oen_in);
endmodule // bip_pin_model
`default_nettype wire

//--- verif/bip_port_tb_top.sv
// Purpose: bench for bip_port
// Assumes: pull-ups on bits 7:6
// Notes: rows run in order, spaced apart
`timescale 1ns/1ps
`default_nettype none
module bip_port_tb_top import bip_port_pkg::*;;
  typedef struct packed {bip_op_t op; logic [2:0] b; logic [7:0] d, e;} bip_row_t;
  logic clk = 0, rstn = 0, start = 0, rv, busy;
  bip_op_t op = BIP_OP_NONE;
  logic [2:0] bsel = 0;
  logic [7:0] din = 0, pins, pout, oen, rdat;
  int errors = 0, compares = 0;
  bip_row_t rows [9] = '{'{BIP_OP_WRITE, 3'h0, 8'h0F, 8'h0F}, '{BIP_OP_DIR_LOAD, 3'h0, 8'hF0, 8'h0F},
    '{BIP_OP_BIT_CLEAR, 3'h7, 8'h00, 8'h4F}, '{BIP_OP_BIT_CLEAR, 3'h6, 8'h00, 8'h8F},
    '{BIP_OP_DIR_LOAD, 3'h0, 8'h3F, 8'h8F}, '{BIP_OP_READ, 3'h0, 8'h00, 8'h80},
    '{BIP_OP_BIT_SET, 3'h0, 8'h00, 8'h81}, '{BIP_OP_DIR_LOAD, 3'h0, 8'h00, 8'h81},
    '{BIP_OP_READ, 3'h0, 8'h00, 8'h81}};
  bip_port bip_port_inst (.core_clk_in(clk), .resetn_in(rstn), .start_in(start), .op_in(op),
    .bit_sel_in(bsel), .data_in(din), .pin_in(pins), .pin_out(pout), .pin_oen_out(oen),
    .read_data_out(rdat), .read_valid_out(rv), .busy_out(busy));
  bip_pin_model bip_pin_model_inst (.drive_in(pout), .oen_in(oen), .ext_in(8'hC0),
    .level_out(pins));
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic run(input bip_row_t r);
    @(posedge clk) #1 {start, op, bsel, din} = {1'b1, r.op, r.b, r.d};
    @(posedge clk) #1 start = 0;
    cmp({7'h00, busy}, 8'h01);
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic close_out;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial forever #5 clk = ~clk;
  initial begin
    repeat (5) @(posedge clk);
    #1 rstn = 1;
    cmp(oen, 8'hFF);
    foreach (rows[i]) begin
      run(rows[i]);
      cmp(rows[i].op == BIP_OP_READ ? rdat : pout, rows[i].e);
      cmp({7'h00, rv}, {7'h00, rows[i].op == BIP_OP_READ});
      cmp({7'h00, busy}, 8'h00);
    end
    rstn = 0;
    repeat (2) @(posedge clk);
    #1 rstn = 1;
    cmp(pout, 8'h00);
    cmp(oen, 8'hFF);
    close_out();
  end
endmodule // bip_port_tb_top
`default_nettype wire
